/* verilog/fws_consts.svh */
// Offsets-free constants: timing figures and sizes for the wheel sequencer
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH

`define FWS_CLK_PERIOD_NS   4
`define FWS_SLOTS_PER_REV   12
`define FWS_SLOTS_PER_GROUP 3
`define FWS_SETS_TO_AVERAGE 8
`define FWS_AVG_SHIFT       3
`define FWS_ADC_BITS        14
`define FWS_FIFO_DEPTH      16

// Least times, rounded up to whole cycles
`define FWS_CYC_CEIL(ns) \
  (((ns) + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)

`define FWS_AUTOZERO_NS     2000
`define FWS_TRACK_DLY_NS    1000
`define FWS_CONV_DLY_NS     400
`define FWS_CONV_PULSE_NS   40
`define FWS_PH_RESET_NS     400
`define FWS_WIDE_MIN_NS     2000000

`define FWS_AUTOZERO_CYC    `FWS_CYC_CEIL(`FWS_AUTOZERO_NS)
`define FWS_TRACK_DLY_CYC   `FWS_CYC_CEIL(`FWS_TRACK_DLY_NS)
`define FWS_CONV_DLY_CYC    `FWS_CYC_CEIL(`FWS_CONV_DLY_NS)
`define FWS_CONV_PULSE_CYC  `FWS_CYC_CEIL(`FWS_CONV_PULSE_NS)
`define FWS_PH_RESET_CYC    `FWS_CYC_CEIL(`FWS_PH_RESET_NS)
`define FWS_WIDE_MIN_CYC    `FWS_CYC_CEIL(`FWS_WIDE_MIN_NS)

`endif

/* verilog/fws_pkg.sv */
// Types shared by the filter wheel sequencer and its bench
package fws_pkg;

  typedef enum logic [1:0] {
    FWS_CMD_HOOD_OPEN,
    FWS_CMD_HOOD_CLOSE,
    FWS_CMD_SYS_ON,
    FWS_CMD_SYS_OFF
  } fws_cmd_code_t;

  typedef struct packed {
    logic          valid;
    fws_cmd_code_t code;
  } fws_cmd_t;

  typedef struct packed {
    logic autozero;
    logic peak_hold_en;
    logic convert;
    logic ph_reset;
  } fws_strobes_t;

  typedef struct packed {
    logic [1:0]  channel;
    logic [13:0] sample;
    logic [13:0] background;
  } fws_result_t;

endpackage : fws_pkg

/* verilog/fws_sequencer.sv */
// Filter wheel slot decoder, strobe sequencer, averager and radio control
// What this block does
// - Accept twelve slot pulses per revolution, four groups of three.
// - First pulse of a group means the filter enters the beam.
// - Second pulse marks the filter midpoint, ending the open phase.
// - Third pulse marks the trailing edge, ending the filter interval.
// - Detect the wide once-per-revolution slot to check group order.
// - One measurement per filter channel each wheel revolution.
// - Signal taken in first half, background in blocked second half.
// - First pulse rising edge fires autozero before each filter signal.
// - Peak/hold, convert and reset strobes come from counted delays.
// - Convert happens while peak is held and before the hold reset.
// - Once blocked, repeat peak/hold and convert for the background.
// - Four sample/background pairs per revolution, in filter order.
// - Collect eight sets, average per channel, release the result.
// - Direction input routes antenna relay to transmitter or receiver.
// - Transmitter power is off whenever direction is not transmit.
// - Hood-open command drives hood line high, hood-close drives it low.
`include "fws_consts.svh"

module fws_fifo #(
  parameter int unsigned WIDTH = 30,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
      if (pop)
      begin
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      end
      if (push && !pop)
      begin
        count_q <= count_q + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end
endmodule : fws_fifo

module fws_sequencer #(
  parameter int unsigned WIDE_MIN_CYC = `FWS_WIDE_MIN_CYC,
  parameter int unsigned FIFO_DEPTH   = `FWS_FIFO_DEPTH
) (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 slot_pulse_in,
  input  wire logic                 adc_done_in,
  input  wire logic [13:0]          adc_data_in,
  input  wire logic                 dir_tx_in,
  input  wire fws_pkg::fws_cmd_t    remote_cmd,
  output fws_pkg::fws_strobes_t     strobes,
  output logic                      relay_to_tx,
  output logic                      tx_power_en,
  output logic                      hood_open,
  output logic                      acquiring,
  output logic                      seq_error,
  output logic                      sync_locked,
  output fws_pkg::fws_result_t      result_data,
  output logic                      result_valid,
  input  wire logic                 result_ready
);
  import fws_pkg::*;

  localparam int unsigned ACC_W = `FWS_ADC_BITS + `FWS_AVG_SHIFT;

  typedef enum logic [2:0] {
    S_IDLE, S_AUTOZERO, S_EN_WAIT, S_TRACK,
    S_CONV_WAIT, S_CONVERT, S_ADC_WAIT, S_RESET
  } fws_seq_t;

  function automatic logic [1:0] slot_phase(input logic [3:0] pos);
    slot_phase = 2'(pos % 4'(`FWS_SLOTS_PER_GROUP));
  endfunction : slot_phase

  function automatic logic [1:0] slot_filter(input logic [3:0] pos);
    slot_filter = 2'(pos / 4'(`FWS_SLOTS_PER_GROUP));
  endfunction : slot_filter

  // Two-flop synchronisers for the pins
  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [2:0]  sync3_q;
  logic [13:0] adc1_q;
  logic [13:0] adc2_q;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      adc1_q  <= '0;
      adc2_q  <= '0;
    end
    else
    begin
      sync1_q <= {dir_tx_in, adc_done_in, slot_pulse_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      adc1_q  <= adc_data_in;
      adc2_q  <= adc1_q;
    end
  end

  logic slot_rise;
  logic slot_fall;
  logic done_rise;
  logic dir_tx;
  assign slot_rise = sync2_q[0] && !sync3_q[0];
  assign slot_fall = !sync2_q[0] && sync3_q[0];
  assign done_rise = sync2_q[1] && !sync3_q[1];
  assign dir_tx    = sync2_q[2];

  // Slot position tracking
  logic [23:0] width_q;
  logic [3:0]  pos_q;
  logic [3:0]  since_wide_q;
  logic        locked_q;
  logic        seq_error_q;
  logic        wide_slot;
  logic        acquire_q;
  logic        acq_start;

  assign acq_start = remote_cmd.valid && remote_cmd.code == FWS_CMD_SYS_ON
                     && !acquire_q;
  assign wide_slot = slot_fall && (width_q >= 24'(WIDE_MIN_CYC));

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      width_q <= '0;
    end
    else if (sync2_q[0])
    begin
      width_q <= (width_q == '1) ? width_q : width_q + 24'(1);
    end
    else
    begin
      width_q <= '0;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pos_q        <= '0;
      since_wide_q <= '0;
      locked_q     <= 1'b0;
    end
    else if (wide_slot)
    begin
      pos_q        <= 4'd1;
      since_wide_q <= '0;
      locked_q     <= 1'b1;
    end
    else if (slot_rise)
    begin
      pos_q <= (pos_q == 4'(`FWS_SLOTS_PER_REV - 1)) ? '0 : pos_q + 4'd1;
      since_wide_q <= (since_wide_q == '1) ? since_wide_q
                                           : since_wide_q + 4'd1;
    end
  end

  // Set wins over the clear at acquisition start
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      seq_error_q <= 1'b0;
    end
    else if (wide_slot && locked_q &&
             since_wide_q != 4'(`FWS_SLOTS_PER_REV))
    begin
      seq_error_q <= 1'b1;
    end
    else if (acq_start)
    begin
      seq_error_q <= 1'b0;
    end
  end

  logic hood_q;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      acquire_q <= 1'b0;
      hood_q    <= 1'b0;
    end
    else if (remote_cmd.valid)
    begin
      case (remote_cmd.code)
        FWS_CMD_HOOD_OPEN:  hood_q    <= 1'b1;
        FWS_CMD_HOOD_CLOSE: hood_q    <= 1'b0;
        FWS_CMD_SYS_ON:     acquire_q <= 1'b1;
        FWS_CMD_SYS_OFF:    acquire_q <= 1'b0;
        default:            hood_q    <= hood_q;
      endcase
    end
  end

  // Strobe sequencer
  fws_seq_t    state_q;
  logic [15:0] timer_q;
  logic [1:0]  filt_q;
  logic        bg_q;
  logic        store;
  logic        dump_q;
  logic        go;

  // Stalls while the averaged set waits for FIFO room
  // one pass per filter
  assign go    = slot_rise && locked_q && acquire_q && !dump_q;
  assign store = (state_q == S_ADC_WAIT) && done_rise;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      timer_q <= '0;
      filt_q  <= '0;
      bg_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          // filter arrival; autozero on its edge
          if (go && slot_phase(pos_q) == 2'd0)
          begin
            filt_q  <= slot_filter(pos_q);
            timer_q <= 16'(`FWS_AUTOZERO_CYC - 1);
            state_q <= S_AUTOZERO;
          end
        end
        S_AUTOZERO:
        begin
          if (timer_q == '0)
          begin
            timer_q <= 16'(`FWS_TRACK_DLY_CYC - 1);
            state_q <= S_EN_WAIT;
          end
          else
          begin
            timer_q <= timer_q - 16'd1;
          end
        end
        S_EN_WAIT:
        begin
          if (timer_q == '0)
          begin
            state_q <= S_TRACK;
          end
          else
          begin
            timer_q <= timer_q - 16'd1;
          end
        end
        S_TRACK:
        begin
          if (go && slot_phase(pos_q) == 2'd0)
          begin
            filt_q  <= slot_filter(pos_q);
            timer_q <= 16'(`FWS_AUTOZERO_CYC - 1);
            state_q <= S_AUTOZERO;
          end
          // unstarted arrival idles
          // A stale filter must not be converted into the wrong channel
          else if (slot_rise && slot_phase(pos_q) == 2'd0)
          begin
            state_q <= S_IDLE;
          end
          // midpoint ends open phase; trailing edge ends bg
          else if (slot_rise)
          begin
            // open half is signal, blocked half is background
            bg_q    <= (slot_phase(pos_q) == 2'd2);
            timer_q <= 16'(`FWS_CONV_DLY_CYC - 1);
            state_q <= S_CONV_WAIT;
          end
        end
        S_CONV_WAIT:
        begin
          if (timer_q == '0)
          begin
            timer_q <= 16'(`FWS_CONV_PULSE_CYC - 1);
            state_q <= S_CONVERT;
          end
          else
          begin
            timer_q <= timer_q - 16'd1;
          end
        end
        S_CONVERT:
        begin
          if (timer_q == '0)
          begin
            state_q <= S_ADC_WAIT;
          end
          else
          begin
            timer_q <= timer_q - 16'd1;
          end
        end
        S_ADC_WAIT:
        begin
          // reset only after conversion; next slot aborts a hang
          if (done_rise || slot_rise)
          begin
            timer_q <= 16'(`FWS_PH_RESET_CYC - 1);
            state_q <= S_RESET;
          end
        end
        S_RESET:
        begin
          if (timer_q != '0)
          begin
            timer_q <= timer_q - 16'd1;
          end
          else if (!bg_q)
          begin
            timer_q <= 16'(`FWS_TRACK_DLY_CYC - 1);
            state_q <= S_EN_WAIT;
          end
          else
          begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  fws_strobes_t strobes_q;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      strobes_q <= '0;
    end
    else
    begin
      strobes_q.autozero     <= (state_q == S_AUTOZERO);
      strobes_q.peak_hold_en <= (state_q == S_TRACK) ||
                                (state_q == S_CONV_WAIT) ||
                                (state_q == S_CONVERT) ||
                                (state_q == S_ADC_WAIT);
      strobes_q.convert      <= (state_q == S_CONVERT);
      strobes_q.ph_reset     <= (state_q == S_RESET);
    end
  end

  // Accumulation and averaging
  logic [ACC_W-1:0] acc_q [8];
  logic [2:0]       set_cnt_q;
  logic [1:0]       dump_idx_q;
  logic             fifo_in_ready;
  logic             dump_done;
  fws_result_t      dump_word;

  assign dump_done = dump_q && fifo_in_ready && dump_idx_q == 2'd3;
  // divide by eight with a shift
  assign dump_word.channel    = dump_idx_q;
  assign dump_word.sample     = 14'(acc_q[{dump_idx_q, 1'b0}]
                                    >> `FWS_AVG_SHIFT);
  assign dump_word.background = 14'(acc_q[{dump_idx_q, 1'b1}]
                                    >> `FWS_AVG_SHIFT);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 8; i++)
      begin
        acc_q[i] <= '0;
      end
    end
    else if (dump_done || acq_start || (wide_slot && locked_q &&
             since_wide_q != 4'(`FWS_SLOTS_PER_REV)))
    begin
      for (int i = 0; i < 8; i++)
      begin
        acc_q[i] <= '0;
      end
    end
    // one sample/background slot per filter; wide sum
    else if (store)
    begin
      acc_q[{filt_q, bg_q}] <= acc_q[{filt_q, bg_q}] + ACC_W'(adc2_q);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      set_cnt_q  <= '0;
      dump_q     <= 1'b0;
      dump_idx_q <= '0;
    end
    else if (dump_q)
    begin
      if (fifo_in_ready)
      begin
        dump_idx_q <= dump_idx_q + 2'd1;
        dump_q     <= !dump_done;
      end
    end
    else if (acq_start || (wide_slot && locked_q &&
             since_wide_q != 4'(`FWS_SLOTS_PER_REV)))
    begin
      set_cnt_q <= '0;
    end
    // eighth complete set releases the average
    else if (store && filt_q == 2'd3 && bg_q)
    begin
      set_cnt_q  <= set_cnt_q + 3'd1;
      dump_q     <= (set_cnt_q == 3'(`FWS_SETS_TO_AVERAGE - 1));
      dump_idx_q <= '0;
    end
  end

  fws_fifo #(
    .WIDTH ($bits(fws_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) fws_fifo_inst (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (dump_q),
    .in_ready  (fifo_in_ready),
    .in_data   (dump_word),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  // relay follows direction; power only when transmitting
  logic relay_q;
  logic power_q;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      relay_q <= 1'b0;
      power_q <= 1'b0;
    end
    else
    begin
      relay_q <= dir_tx;
      // Power waits for the relay, but drops at once
      power_q <= dir_tx && relay_q;
    end
  end

  assign strobes     = strobes_q;
  assign relay_to_tx = relay_q;
  assign tx_power_en = power_q;
  assign hood_open   = hood_q;
  assign acquiring   = acquire_q;
  assign seq_error   = seq_error_q;
  assign sync_locked = locked_q;
endmodule : fws_sequencer

/* sim/fws_sequencer_props.sv */
// Port-level checker for the filter wheel sequencer
module fws_sequencer_props #(
  parameter int unsigned WIDE_MIN_CYC = 500000,
  parameter int unsigned FIFO_DEPTH   = 16
) (
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  slot_pulse_in,
  input wire logic                  adc_done_in,
  input wire logic [13:0]           adc_data_in,
  input wire logic                  dir_tx_in,
  input wire fws_pkg::fws_cmd_t     remote_cmd,
  input wire fws_pkg::fws_strobes_t strobes,
  input wire logic                  relay_to_tx,
  input wire logic                  tx_power_en,
  input wire logic                  hood_open,
  input wire logic                  acquiring,
  input wire logic                  seq_error,
  input wire logic                  sync_locked,
  input wire fws_pkg::fws_result_t  result_data,
  input wire logic                  result_valid,
  input wire logic                  result_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import fws_pkg::*;
  logic [9:0] az_q;
  logic [7:0] pr_q;
  logic       on_cmd;
  assign on_cmd = remote_cmd.valid && remote_cmd.code == FWS_CMD_SYS_ON;
  // Pulse widths counted, too long for repetition
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      az_q <= 10'h000;
    else
      az_q <= strobes.autozero ? az_q + 10'h001 : 10'h000;
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      pr_q <= 8'h00;
    else
      pr_q <= strobes.ph_reset ? pr_q + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  property p_az_len;
    $fell(strobes.autozero) |-> az_q == 10'h1F4;
  endproperty
  a_az_len: assert property (p_az_len)
    else $error("autozero width wrong");
  property p_az_cause;
    $rose(strobes.autozero) |-> ($past(slot_pulse_in, 3) ||
      $past(slot_pulse_in, 4)) && acquiring && sync_locked;
  endproperty
  a_az_cause: assert property (p_az_cause)
    else $error("autozero without slot edge");
  property p_conv_len;
    $rose(strobes.convert) |-> strobes.convert[*5] ##1
      strobes.convert[*5] ##1 !strobes.convert;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("convert width wrong");
  property p_pr_len;
    $fell(strobes.ph_reset) |-> pr_q == 8'h64;
  endproperty
  a_pr_len: assert property (p_pr_len)
    else $error("hold reset width wrong");
  property p_conv_held;
    strobes.convert |-> strobes.peak_hold_en && !strobes.ph_reset;
  endproperty
  a_conv_held: assert property (p_conv_held)
    else $error("convert outside hold");
  property p_relay_on;
    $rose(dir_tx_in) |-> ##[2:4] relay_to_tx;
  endproperty
  a_relay_on: assert property (p_relay_on)
    else $error("relay not to transmitter");
  property p_relay_off;
    $fell(dir_tx_in) |-> ##[2:4] !relay_to_tx;
  endproperty
  a_relay_off: assert property (p_relay_off)
    else $error("relay not to receiver");
  property p_txpwr;
    !relay_to_tx |-> !tx_power_en;
  endproperty
  a_txpwr: assert property (p_txpwr)
    else $error("transmitter powered in receive");
  property p_hood_op;
    remote_cmd.valid && remote_cmd.code == FWS_CMD_HOOD_OPEN
      |-> ##[1:2] hood_open;
  endproperty
  a_hood_op: assert property (p_hood_op)
    else $error("hood line not high");
  property p_hood_cl;
    remote_cmd.valid && remote_cmd.code == FWS_CMD_HOOD_CLOSE
      |-> ##[1:2] !hood_open;
  endproperty
  a_hood_cl: assert property (p_hood_cl)
    else $error("hood line not low");
  property p_acq_on;
    on_cmd |-> ##[1:2] acquiring;
  endproperty
  a_acq_on: assert property (p_acq_on)
    else $error("acquisition not started");
  property p_err_sticky;
    seq_error && !on_cmd && !$past(on_cmd) |=> seq_error;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("sequence error dropped");
  property p_fifo_hold;
    result_valid && !result_ready |=> result_valid && $stable(result_data);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("result changed while stalled");
  c_conv: cover property ($rose(strobes.convert));
  c_pop: cover property (result_valid && result_ready);
  c_err: cover property ($rose(seq_error));
endmodule : fws_sequencer_props

bind fws_sequencer fws_sequencer_props #(
  .WIDE_MIN_CYC(WIDE_MIN_CYC),
  .FIFO_DEPTH(FIFO_DEPTH)
) fws_sequencer_props_inst (
  .clock(clock), .reset(reset), .slot_pulse_in(slot_pulse_in),
  .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
  .dir_tx_in(dir_tx_in), .remote_cmd(remote_cmd), .strobes(strobes),
  .relay_to_tx(relay_to_tx), .tx_power_en(tx_power_en),
  .hood_open(hood_open), .acquiring(acquiring), .seq_error(seq_error),
  .sync_locked(sync_locked), .result_data(result_data),
  .result_valid(result_valid), .result_ready(result_ready)
);

/* sim/fws_adc_model.sv */
// Converter card model answering each convert strobe
module fws_adc_model (
  input  wire logic                  clock,
  input  wire fws_pkg::fws_strobes_t strobes,
  input  wire logic                  restart,
  input  wire logic                  slow,
  output logic                       adc_done_in,
  output logic [13:0]                adc_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import fws_pkg::*;
  int unsigned k;
  initial
  begin
    adc_done_in = 1'b0;
    adc_data_in = 14'h0000;
    k = 0;
  end
  // answers every convert, value encodes slot of set
  always
  begin
    @(posedge clock);
    if (restart)
      k = 0;
    else if (strobes.convert)
    begin
      repeat (slow ? 40 : 4) @(posedge clock);
      #1 adc_data_in = 14'(((k % 8) << 8) + k / 8);
      repeat (3) @(posedge clock);
      #1 adc_done_in = 1'b1;
      repeat (4) @(posedge clock);
      #1 adc_done_in = 1'b0;
      repeat (3) @(posedge clock);
      // Released data must not look valid
      #1 adc_data_in = ~adc_data_in;
      k = k + 1;
      while (strobes.convert)
        @(posedge clock);
    end
  end
endmodule : fws_adc_model

/* sim/fws_sequencer_bench.sv */
// Self-checking bench for the filter wheel sequencer
module fws_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import fws_pkg::*;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         slot_pulse_in = 1'b0;
  logic         dir_tx_in = 1'b0;
  logic         result_ready = 1'b0;
  logic         restart = 1'b0;
  logic         slow = 1'b0;
  fws_cmd_t     remote_cmd = '0;
  logic         adc_done_in;
  logic [13:0]  adc_data_in;
  fws_strobes_t strobes;
  fws_result_t  result_data;
  logic         relay_to_tx, tx_power_en, hood_open, acquiring;
  logic         seq_error, sync_locked, result_valid;
  int           num_errors = 0;
  int           checks = 0;
  int           n_az = 0;
  int           n_cv = 0;

  always #2 clock = ~clock;
  always @(posedge clock)
  begin
    if ($rose(strobes.autozero))
      n_az = n_az + 1;
    if ($rose(strobes.convert))
      n_cv = n_cv + 1;
  end

  fws_sequencer #(.WIDE_MIN_CYC(20), .FIFO_DEPTH(16)) fws_sequencer_inst (
    .clock(clock), .reset(reset), .slot_pulse_in(slot_pulse_in),
    .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
    .dir_tx_in(dir_tx_in), .remote_cmd(remote_cmd), .strobes(strobes),
    .relay_to_tx(relay_to_tx), .tx_power_en(tx_power_en),
    .hood_open(hood_open), .acquiring(acquiring), .seq_error(seq_error),
    .sync_locked(sync_locked), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready)
  );
  fws_adc_model fws_adc_model_inst (
    .clock(clock), .strobes(strobes), .restart(restart), .slow(slow),
    .adc_done_in(adc_done_in), .adc_data_in(adc_data_in)
  );

  task tick;
    @(posedge clock);
    #1;
  endtask : tick
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Wide slot 40 cycles, narrow 5; gap must outlast one strobe phase
  task slot(input logic wide, input int gap);
    slot_pulse_in = 1'b1;
    repeat (wide ? 40 : 5) tick;
    slot_pulse_in = 1'b0;
    repeat (gap) tick;
  endtask : slot
  task rev(input int gap);
    slot(1'b1, gap);
    repeat (11) slot(1'b0, gap);
  endtask : rev
  task cmd(input fws_cmd_code_t c);
    remote_cmd = '{1'b1, c};
    tick;
    remote_cmd = '0;
    repeat (3) tick;
  endtask : cmd

  task t_reset;
    chk({strobes, relay_to_tx, tx_power_en, hood_open, acquiring,
         seq_error, sync_locked, result_valid}, 32'h0);
  endtask : t_reset
  task t_radio;
    dir_tx_in = 1'b1;
    repeat (8) tick;
    chk({relay_to_tx, tx_power_en}, 32'h3);
    dir_tx_in = 1'b0;
    repeat (8) tick;
    chk({relay_to_tx, tx_power_en}, 32'h0);
  endtask : t_radio
  task t_cmds;
    logic [1:0] exp [4];
    exp = '{2'b10, 2'b00, 2'b01, 2'b00};
    for (int i = 0; i < 4; i++)
    begin
      cmd(fws_cmd_code_t'(i));
      chk({hood_open, acquiring}, exp[i]);
    end
  endtask : t_cmds
  task t_lock;
    n_az = 0;
    rev(60);
    chk(sync_locked, 1);
    chk(n_az, 0);
  endtask : t_lock
  task t_average;
    int i;
    restart = 1'b1;
    cmd(FWS_CMD_SYS_ON);
    restart = 1'b0;
    n_az = 0;
    n_cv = 0;
    for (int r = 0; r < 8; r++)
    begin
      slow = r[0];
      rev(795);
    end
    chk(n_az, 32);
    chk(n_cv, 64);
    chk(seq_error, 0);
    for (i = 0; i < 300 && result_valid !== 1'b1; i++)
      tick;
    // Sink stalls before taking the averaged set
    repeat (20) tick;
    chk(result_valid, 1);
    for (int c = 0; c < 4; c++)
    begin
      chk(result_data, {2'(c), 14'(c * 512 + 3),
          14'(c * 512 + 259)});
      result_ready = 1'b1;
      tick;
      result_ready = 1'b0;
      tick;
    end
    chk(result_valid, 0);
  endtask : t_average
  task t_seq_err;
    cmd(FWS_CMD_SYS_OFF);
    slot(1'b1, 60);
    repeat (5) slot(1'b0, 60);
    slot(1'b1, 60);
    chk(seq_error, 1);
    repeat (11) slot(1'b0, 60);
    slot(1'b1, 60);
    chk(seq_error, 1);
    cmd(FWS_CMD_SYS_ON);
    chk(seq_error, 0);
  endtask : t_seq_err

  initial
  begin
    repeat (5) @(posedge clock);
    #1 reset = 1'b0;
    tick;
    t_reset;
    t_radio;
    t_cmds;
    t_lock;
    t_average;
    t_seq_err;
    end_of_test;
  end
endmodule : fws_sequencer_bench
